//--- dv/internal_osc_tune_pll_tb.sv
// Purpose: self-checking bench of the oscillator trim block
// Assumes: 100 MHz clock, classic single Wishbone cycles
// Notes:   ticks: high every cycle, mid every 2nd, low every 4th
`timescale 1ns/100ps
module internal_osc_tune_pll_tb;
   logic        clock = 1'b0, sys_rst = 1'b1, wbWe = 1'b0, wbCyc = 1'b0, wbStb = 1'b0, wbAck;
   logic        highOscTick = 1'b1, midOscTick = 1'b0, lowOscTick = 1'b0;
   logic        multiplierEnableCfg = 1'b0, primaryIsExternal = 1'b0;
   logic        lowOscClock, internalClockOutput, multiplierEnable;
   logic [3:0]  wbAdr = 4'h0, wbSel = 4'h0;
   logic [31:0] wbDatIn = 32'h0, wbDatOut, rd;
   logic [5:0]  highOscTrim, midOscTrim, curTrim = 6'h0;
   logic [2:0]  multiplierFactor;
   logic [1:0]  phase = 2'h0;
   logic [7:0]  v;
   logic        e;
   int          failures = 0, compares = 0, d;
   always #5 clock = ~clock;
   always @(posedge clock)
   begin
      phase <= phase + 2'h1;
      midOscTick <= phase[0];
      lowOscTick <= (phase == 2'h3);
   end
   internal_osc_tune_pll internal_osc_tune_pll_inst
   (.clock(clock), .sys_rst(sys_rst), .wbAdr(wbAdr), .wbDatIn(wbDatIn), .wbDatOut(wbDatOut),
    .wbSel(wbSel), .wbWe(wbWe), .wbCyc(wbCyc), .wbStb(wbStb), .wbAck(wbAck),
    .highOscTick(highOscTick), .midOscTick(midOscTick), .lowOscTick(lowOscTick),
    .multiplierEnableCfg(multiplierEnableCfg), .primaryIsExternal(primaryIsExternal),
    .highOscTrim(highOscTrim), .midOscTrim(midOscTrim), .lowOscClock(lowOscClock),
    .internalClockOutput(internalClockOutput), .multiplierEnable(multiplierEnable),
    .multiplierFactor(multiplierFactor));
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic results;
      if (failures == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : results
   task automatic hang;
      failures++;
      results();
   endtask : hang
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         failures++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic bus(input logic we, input logic [3:0] adr, input logic [7:0] dat,
                      input logic [3:0] sel, output logic [31:0] data);
      int n;
      n = 0;
      @(posedge clock);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= adr;
      wbSel <= sel;
      wbDatIn <= {24'h0, dat};
      do
      begin
         @(posedge clock);
         n++;
      end
      while (wbAck !== 1'b1 && n < 20);
      if (n >= 20)
         hang();
      data = wbDatOut;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
   endtask : bus
   // skip two pulses: a new select only lands at a period boundary
   task automatic period(input int exp);
      int n;
      for (int k = 0; k < 3; k++)
      begin
         n = 0;
         do
         begin
            @(posedge clock);
            n++;
         end
         while (internalClockOutput !== 1'b1 && n < 2000);
         if (n >= 2000)
            hang();
      end
      chk("period", 32'(exp), 32'(n));
   endtask : period
   function automatic int expPeriod(input logic [2:0] f, input logic m, input logic lsrc);
      if (f >= 3'h3)
         return 1 << (7 - f);
      if (f == 3'h0 && !lsrc)
         return 4;
      if (m)
         return (f == 3'h2) ? 2 : (f == 3'h1) ? 4 : 32;
      return (f == 3'h2) ? 32 : (f == 3'h1) ? 64 : 512;
   endfunction : expPeriod
   // ----------------------------------------------------------------
   // sequence
   // ----------------------------------------------------------------
   initial
   begin
      void'($urandom(18420));
      repeat (10) @(posedge clock);
      sys_rst <= 1'b0;
      bus(1'b0, 4'h0, 8'h00, 4'hf, rd);
      chk("trimReset", 32'h0, rd);
      bus(1'b0, 4'h4, 8'h00, 4'hf, rd);
      chk("freqReset", 32'h3, rd);
      period(16);
      bus(1'b0, 4'hc, 8'h00, 4'hf, rd);
      chk("unmapped", 32'h0, rd);
      bus(1'b1, 4'h0, 8'h55, 4'h0, rd);
      bus(1'b1, 4'h8, 8'h55, 4'hf, rd);
      bus(1'b0, 4'h0, 8'h00, 4'hf, rd);
      chk("dropped", 32'h0, rd);
      bus(1'b1, 4'h0, 8'h80, 4'hf, rd);
      for (int i = 0; i < 17; i++)
      begin
         if (i == 16)
            bus(1'b1, 4'h0, 8'h00, 4'hf, rd);
         bus(1'b1, 4'h4, (i < 16) ? {4'h0, i[0], i[3:1]} : 8'h00, 4'hf, rd);
         period(expPeriod(i[3:1], i[0], i < 16));
      end
      for (int i = 0; i < 8; i++)
      begin
         // multiplier enabled by bit 6, or by the fuse with an external source, while the 31 kHz select is in place
         bus(1'b1, 4'h0, {1'b0, i[2], 6'h0}, 4'hf, rd);
         primaryIsExternal <= i[1];
         multiplierEnableCfg <= i[0];
         repeat (3) @(posedge clock);
         e = i[2] | (i[1] & i[0]);
         chk("multEnable", {31'h0, e}, {31'h0, multiplierEnable});
         chk("multFactor", e ? 32'h4 : 32'h1, {29'h0, multiplierFactor});
      end
      for (int i = 0; i < 6; i++)
      begin
         v = (i < 3) ? 8'($urandom) : (i == 3) ? 8'h1f : (i == 4) ? 8'h20 : 8'h00;
         bus(1'b1, 4'h0, v, 4'hf, rd);
         bus(1'b0, 4'h0, 8'h00, 4'hf, rd);
         chk("trimRead", {24'h0, v}, rd);
         d = int'($signed(v[5:0])) - int'($signed(curTrim));
         if (d < 0)
            d = -d;
         curTrim = v[5:0];
         if (d > 1)
         begin
            repeat (d * 100 - 150) @(posedge clock);
            chk("trimEarly", 32'h0, {31'h0, highOscTrim === curTrim});
         end
         repeat (250) @(posedge clock);
         chk("highTrim", {26'h0, curTrim}, {26'h0, highOscTrim});
         chk("midTrim", {26'h0, curTrim}, {26'h0, midOscTrim});
         bus(1'b0, 4'h8, 8'h00, 4'hf, rd);
         chk("status", {25'h0, 1'b1, curTrim}, {25'h0, rd[6:0]});
      end
      results();
   end
endmodule : internal_osc_tune_pll_tb

//--- dv/osc_tune_monitor.sv
// Purpose: port-level checks of the oscillator trim block
// Assumes: one clock, synchronous active-high reset
// Notes:   attached by the bind at the foot of this file
`timescale 1ns/100ps
`include "osc_tune_defs.svh"
module osc_tune_monitor
(
   input wire logic        clock,
   input wire logic        sys_rst,
   input wire logic        wbCyc,
   input wire logic        wbStb,
   input wire logic        wbAck,
   input wire logic [31:0] wbDatOut,
   input wire logic        highOscTick,
   input wire logic        midOscTick,
   input wire logic        lowOscTick,
   input wire logic        multiplierEnableCfg,
   input wire logic        primaryIsExternal,
   input wire logic [5:0]  highOscTrim,
   input wire logic        lowOscClock,
   input wire logic        internalClockOutput,
   input wire logic        multiplierEnable,
   input wire logic [2:0]  multiplierFactor
);
   default clocking mon_cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);
   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   ack_latency_a: assert property ((wbCyc && wbStb && !wbAck) |=> wbAck)
      else $error("request not acked one cycle after taking");
   idle_data_a: assert property (!wbAck |-> wbDatOut == 32'h0)
      else $error("read data nonzero outside ack");
   mult_fuse_a: assert property (
      (!sys_rst && primaryIsExternal && multiplierEnableCfg) |=> multiplierEnable)
      else $error("fuse with external source left multiplier off");
   mult_factor_a: assert property (
      multiplierFactor == (multiplierEnable ? `PLL_FACTOR : `NO_MULT_FACTOR))
      else $error("multiplier factor does not follow enable");
   trim_step_a: assert property (
      $changed(highOscTrim) |-> (highOscTrim == $past(highOscTrim) + 6'h01)
                                || (highOscTrim == $past(highOscTrim) - 6'h01))
      else $error("trim moved by more than one step");
   trim_hold_a: assert property (
      $changed(highOscTrim) |=> $stable(highOscTrim) [*8])
      else $error("trim steps too close together");
   low_clock_a: assert property (
      !sys_rst |=> lowOscClock == $past(lowOscTick))
      else $error("low clock does not follow its tick");
   clk_source_a: assert property (
      internalClockOutput |-> $past(highOscTick || midOscTick || lowOscTick))
      else $error("internal clock pulse without a source tick");
endmodule : osc_tune_monitor
bind internal_osc_tune_pll osc_tune_monitor osc_tune_monitor_inst
(
   .clock(clock), .sys_rst(sys_rst), .wbCyc(wbCyc), .wbStb(wbStb), .wbAck(wbAck),
   .wbDatOut(wbDatOut), .highOscTick(highOscTick), .midOscTick(midOscTick),
   .lowOscTick(lowOscTick), .multiplierEnableCfg(multiplierEnableCfg),
   .primaryIsExternal(primaryIsExternal), .highOscTrim(highOscTrim), .lowOscClock(lowOscClock),
   .internalClockOutput(internalClockOutput), .multiplierEnable(multiplierEnable),
   .multiplierFactor(multiplierFactor)
);

//--- rtl/internal_osc_tune_pll.sv
// Purpose: internal oscillator trim, low-frequency source, divider/mux and 4x multiplier enable
// Assumes: oscillator ticks are one-cycle enables from logic on the same clock
// Notes:   oscillators are modelled as tick streams; trim and multiplier are control outputs
//
// Summary of operation
// RULE1: bit 7 set takes the 31.25 kHz clock from the mid or high oscillator, clear from the low.
// RULE2: bit 6 turns the 4x multiplier on or off, except that with an external source the fuse also turns it on.
// RULE3: the 6-bit trim is two's complement, 011111 fastest, 100000 slowest, 000000 factory value.
// RULE4: trim acts on the mid and high oscillators only, never on the low one.
// RULE5: the high oscillator runs at 16 MHz and the mid one at 500 kHz, both trimmable.
// RULE6: the untrimmed low oscillator clocks the power-up timer, watchdog and clock-fail monitor.
// RULE7: the low oscillator can feed the primary clock and the internal clock mux.
// RULE8: high and mid oscillators feed a divider from 16 MHz to 31.25 kHz, muxed with the low one.
// RULE9: frequency select, mid select and low source select choose one of eight rates.
// RULE10: after reset the internal rate is 1 MHz until software changes the select.
// RULE11: 500 and 250 kHz come from mid or high, 31 kHz from low, mid or high.
// RULE12: with an external source the multiplier is on if the fuse or the software bit is set.
// RULE13: the multiplier raises its input by four, up to 64 MHz.
// RULE14: with the high internal oscillator only the software bit controls the multiplier.
// RULE15: software enables the multiplier only for 4 to 16 MHz inputs.
// RULE16: a trim write shifts the oscillators gradually with no completion flag.
// RULE17: the divider and mux change selection only at output clock boundaries.
`timescale 1ns/100ps
`include "osc_tune_defs.svh"

module internal_osc_tune_pll
(
   input  wire logic        clock,
   input  wire logic        sys_rst,
   input  wire logic [3:0]  wbAdr,
   input  wire logic [31:0] wbDatIn,
   output logic      [31:0] wbDatOut,
   input  wire logic [3:0]  wbSel,
   input  wire logic        wbWe,
   input  wire logic        wbCyc,
   input  wire logic        wbStb,
   output logic             wbAck,
   input  wire logic        highOscTick,
   input  wire logic        midOscTick,
   input  wire logic        lowOscTick,
   input  wire logic        multiplierEnableCfg,
   input  wire logic        primaryIsExternal,
   output logic      [5:0]  highOscTrim,
   output logic      [5:0]  midOscTrim,
   output logic             lowOscClock,
   output logic             internalClockOutput,
   output logic             multiplierEnable,
   output logic      [2:0]  multiplierFactor
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic                   [7:0]  trimControl;
   logic                   [7:0]  next_trimControl;
   logic                   [2:0]  freqSelect;
   logic                   [2:0]  next_freqSelect;
   logic                          midSelect;
   logic                          next_midSelect;
   logic                   [31:0] next_wbDatOut;
   logic                          next_wbAck;
   logic                   [5:0]  trimApplied;
   logic                   [5:0]  next_trimApplied;
   logic                   [6:0]  stepCount;
   logic                   [6:0]  next_stepCount;
   osc_tune_pkg::osc_src_t        activeSrc;
   osc_tune_pkg::osc_src_t        next_activeSrc;
   logic                   [9:0]  activeDiv;
   logic                   [9:0]  next_activeDiv;
   logic                   [9:0]  divCount;
   logic                   [9:0]  next_divCount;
   logic                          next_internalClockOutput;
   logic                          next_lowOscClock;
   logic                          next_multiplierEnable;
   logic                   [2:0]  next_multiplierFactor;

   logic                          busWrite;
   logic                          busRead;
   logic                          srcTick;
   logic                   [12:0] wantSel;

   // ----------------------------------------------------------------
   // rate decode: {source, divisor} for a select combination
   // ----------------------------------------------------------------
   function automatic logic [12:0] rate_decode
   (
      input logic [2:0] fsel,
      input logic       midSel,
      input logic       lowFromInternal
   );
      logic [12:0] r;
      r = {osc_tune_pkg::SRC_HF, 10'h001};
      unique case (fsel)
         `FSEL_16M:  r = {osc_tune_pkg::SRC_HF, 10'h001};
         `FSEL_8M:   r = {osc_tune_pkg::SRC_HF, 10'h002};
         `FSEL_4M:   r = {osc_tune_pkg::SRC_HF, 10'h004};
         `FSEL_2M:   r = {osc_tune_pkg::SRC_HF, 10'h008};
         `FSEL_1M:   r = {osc_tune_pkg::SRC_HF, 10'h010};
         `FSEL_500K: r = midSel ? {osc_tune_pkg::SRC_MF, 10'h001}       // see RULE11
                                : {osc_tune_pkg::SRC_HF, 10'h020};
         `FSEL_250K: r = midSel ? {osc_tune_pkg::SRC_MF, 10'h002}
                                : {osc_tune_pkg::SRC_HF, 10'h040};
         `FSEL_31K:
         begin
            if (!lowFromInternal)
               r = {osc_tune_pkg::SRC_LF, 10'h001};                      // see RULE1
            else if (midSel)
               r = {osc_tune_pkg::SRC_MF, 10'h010};
            else
               r = {osc_tune_pkg::SRC_HF, 10'h200};
         end
      endcase
      return r;
   endfunction : rate_decode

   // ----------------------------------------------------------------
   // register bus
   // ----------------------------------------------------------------
   // ack comes one cycle after the request and drops the next cycle
   assign busWrite = wbCyc && wbStb && wbWe && !wbAck;
   assign busRead  = wbCyc && wbStb && !wbWe && !wbAck;

   always_comb
   begin
      next_trimControl = trimControl;
      next_freqSelect  = freqSelect;
      next_midSelect   = midSelect;
      next_wbAck       = wbCyc && wbStb && !wbAck;
      next_wbDatOut    = 32'h0000_0000;
      if (busWrite && wbSel[0])
      begin
         unique case (wbAdr)
            `ADDR_TRIM_CONTROL: next_trimControl = wbDatIn[7:0];
            `ADDR_FREQ_CONTROL:
            begin
               next_freqSelect = wbDatIn[2:0];                           // see RULE9
               next_midSelect  = wbDatIn[3];
            end
            default: ;
         endcase
      end
      if (busRead)
      begin
         unique case (wbAdr)
            `ADDR_TRIM_CONTROL: next_wbDatOut = {24'h00_0000, trimControl};
            `ADDR_FREQ_CONTROL: next_wbDatOut = {28'h000_0000, midSelect, freqSelect};
            `ADDR_TRIM_STATUS:  next_wbDatOut = {22'h00_0000, activeSrc, multiplierEnable,
                                                 trimApplied};
            default:            next_wbDatOut = 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // trim ramp
   // ----------------------------------------------------------------
   // one trim step per interval; the target is signed so compare signed
   always_comb
   begin
      next_trimApplied = trimApplied;
      next_stepCount   = stepCount;
      if (trimApplied == trimControl[`TRIM_MSB:0])
         next_stepCount = 7'h00;
      else if (stepCount == 7'(`TRIM_STEP_CYCLES - 1))
      begin
         next_stepCount = 7'h00;
         if ($signed(trimControl[`TRIM_MSB:0]) > $signed(trimApplied))  // see RULE3
            next_trimApplied = trimApplied + 6'h01;                      // see RULE16
         else
            next_trimApplied = trimApplied - 6'h01;
      end
      else
         next_stepCount = stepCount + 7'h01;
   end

   // ----------------------------------------------------------------
   // divider and mux
   // ----------------------------------------------------------------
   assign wantSel = rate_decode(freqSelect, midSelect, trimControl[`BIT_LOW_SRC_SEL]);

   always_comb
   begin
      unique case (activeSrc)
         osc_tune_pkg::SRC_HF: srcTick = highOscTick;                    // see RULE8
         osc_tune_pkg::SRC_MF: srcTick = midOscTick;
         osc_tune_pkg::SRC_LF: srcTick = lowOscTick;                     // see RULE7
         default:              srcTick = 1'b0;
      endcase
   end

   always_comb
   begin
      next_activeSrc           = activeSrc;
      next_activeDiv           = activeDiv;
      next_divCount            = divCount;
      next_internalClockOutput = 1'b0;
      if (srcTick)
      begin
         if (divCount >= activeDiv - 10'h001)
         begin
            next_internalClockOutput = 1'b1;
            next_divCount            = 10'h000;
            // new selection only after a whole output period, so no runt
            next_activeSrc = osc_tune_pkg::osc_src_t'(wantSel[12:10]);  // see RULE17
            next_activeDiv = wantSel[9:0];
         end
         else
            next_divCount = divCount + 10'h001;
      end
   end

   // ----------------------------------------------------------------
   // multiplier and fixed outputs
   // ----------------------------------------------------------------
   always_comb
   begin
      // fuse counts only with an external primary source
      next_multiplierEnable = trimControl[`BIT_MULT_EN_SW]                // see RULE2
                              || (primaryIsExternal && multiplierEnableCfg); // see RULE12
      if (!primaryIsExternal)
         next_multiplierEnable = trimControl[`BIT_MULT_EN_SW];           // see RULE14
      next_multiplierFactor = next_multiplierEnable ? `PLL_FACTOR : `NO_MULT_FACTOR; // see RULE13
      next_lowOscClock      = lowOscTick;                                // see RULE6
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         trimControl         <= `TRIM_CONTROL_RESET;
         freqSelect          <= `FREQ_SEL_RESET;                         // see RULE10
         midSelect           <= `MID_SEL_RESET;
         wbDatOut            <= 32'h0000_0000;
         wbAck               <= 1'b0;
         trimApplied         <= 6'h00;
         stepCount           <= 7'h00;
         activeSrc           <= osc_tune_pkg::SRC_HF;
         activeDiv           <= 10'h010;
         divCount            <= 10'h000;
         internalClockOutput <= 1'b0;
         lowOscClock         <= 1'b0;
         multiplierEnable    <= 1'b0;
         multiplierFactor    <= `NO_MULT_FACTOR;
         highOscTrim         <= 6'h00;
         midOscTrim          <= 6'h00;
      end
      else
      begin
         trimControl         <= next_trimControl;
         freqSelect          <= next_freqSelect;
         midSelect           <= next_midSelect;
         wbDatOut            <= next_wbDatOut;
         wbAck               <= next_wbAck;
         trimApplied         <= next_trimApplied;
         stepCount           <= next_stepCount;
         activeSrc           <= next_activeSrc;
         activeDiv           <= next_activeDiv;
         divCount            <= next_divCount;
         internalClockOutput <= next_internalClockOutput;
         lowOscClock         <= next_lowOscClock;
         multiplierEnable    <= next_multiplierEnable;
         multiplierFactor    <= next_multiplierFactor;
         // low oscillator has no trim port at all
         highOscTrim         <= next_trimApplied;                        // see RULE4
         midOscTrim          <= next_trimApplied;                        // see RULE5
      end
   end

endmodule : internal_osc_tune_pll

//--- rtl/osc_tune_defs.svh
// Purpose: offsets, field positions, reset values and timing counts of the trim block
// Assumes: 100 MHz bus clock
// Notes:   included by bare name
`ifndef OSC_TUNE_DEFS_SVH
`define OSC_TUNE_DEFS_SVH

// ----------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------
`define ADDR_TRIM_CONTROL   4'h0
`define ADDR_FREQ_CONTROL   4'h4
`define ADDR_TRIM_STATUS    4'h8

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define BIT_LOW_SRC_SEL     7
`define BIT_MULT_EN_SW      6
`define TRIM_MSB            5
`define TRIM_CONTROL_RESET  8'h00
`define FREQ_SEL_RESET      3'h3
`define MID_SEL_RESET       1'b0

// ----------------------------------------------------------------
// frequency select codes
// ----------------------------------------------------------------
`define FSEL_16M            3'h7
`define FSEL_8M             3'h6
`define FSEL_4M             3'h5
`define FSEL_2M             3'h4
`define FSEL_1M             3'h3
`define FSEL_500K           3'h2
`define FSEL_250K           3'h1
`define FSEL_31K            3'h0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS       10
`define TRIM_STEP_NS        1000
`define TRIM_STEP_CYCLES    (`TRIM_STEP_NS / `CLK_PERIOD_NS)
`define PLL_FACTOR          3'h4
`define NO_MULT_FACTOR      3'h1

`endif

//--- rtl/osc_tune_pkg.sv
// Purpose: types shared by the trim block
// Assumes: nothing
// Notes:   constants live in osc_tune_defs.svh
package osc_tune_pkg;

   // one-hot oscillator feeding the divider
   typedef enum logic [2:0]
   {
      SRC_HF = 3'b001,
      SRC_MF = 3'b010,
      SRC_LF = 3'b100
   } osc_src_t;

endpackage : osc_tune_pkg
